/* File: hdl/pmcd_map.svh */
`ifndef PMCD_MAP_SVH
`define PMCD_MAP_SVH

// Response codes and fixed response words
`define PMCD_RC_OK 10'h1E1
`define PMCD_RC_ERR 10'h1E2
`define PMCD_ENTER_ACK 10'h0CA
`define PMCD_WORD_ZERO 10'h000
`define PMCD_ERROR_NUMBER_PAD 6'h00
`define PMCD_BYTE_PAD 2'h0

// Error numbers that can be emitted
`define PMCD_ERROR_NUMBER_FRAMING 4'h1
`define PMCD_ERROR_NUMBER_CRC 4'h2

// Function codes
`define PMCD_FC_ENTER 3'h7
`define PMCD_FC_READ 3'h0
`define PMCD_FC_WRITE 3'h1

// Command CRC: x^3+x+1, seed all ones, three zeros appended
`define PMCD_CRC_SEED 3'h7
`define PMCD_CRC_POLY 3'h3
`define PMCD_CRC_PAD_BITS 3

// Frame layout: start bits S2 S1 S0 = 0 1 0, payload bits before CRC
`define PMCD_START_PATTERN 3'h2
`define PMCD_PAYLOAD_SHORT 5'h06
`define PMCD_PAYLOAD_LONG 5'h10
`define PMCD_PAYLOAD_XLONG 5'h16
`define PMCD_CRC_LAST 5'h02
`define PMCD_SYNC_PHASE 2'h3
`define PMCD_ZERO_RUN_LIMIT 3'h4

// Response lengths in words
`define PMCD_RESP_SHORT 2'h2
`define PMCD_RESP_XLONG 2'h3

// Default sensor address and timing
`define PMCD_SENSOR_SELECT 3'h1
`define PMCD_BIT_WINDOW_NS 32000
`define PMCD_CLK_PERIOD_NS 10

`endif

/* File: hdl/pmcd_pkg.sv */
package pmcd_pkg;

  // Decoder sequencing states
  typedef enum logic [2:0] {
    pmcd_st_idle = 3'b000,
    pmcd_st_rx = 3'b001,
    pmcd_st_exec = 3'b010,
    pmcd_st_rd_even = 3'b011,
    pmcd_st_rd_odd = 3'b100,
    pmcd_st_wr_wait = 3'b101,
    pmcd_st_wr_back = 3'b110,
    pmcd_st_resp = 3'b111
  } pmcd_state_t;

  typedef logic [9:0] pmcd_word_t;

endpackage

/* File: hdl/pmcd_decoder.sv */
`timescale 1ns/10ps
`include "pmcd_map.svh"
module pmcd_decoder #(
  parameter logic [2:0] SENSOR_SELECT = `PMCD_SENSOR_SELECT,
  parameter int BIT_WINDOW_CYC = `PMCD_BIT_WINDOW_NS / `PMCD_CLK_PERIOD_NS
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic reset,
  // Decoded sync pulses from the bus front end
  input wire logic sync_pulse,
  input wire logic sync_bit,
  // Register file access
  output logic [7:0] register_index,
  output logic reg_wr_en,
  output logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  // Response words toward the bus transmitter
  output logic resp_valid,
  output pmcd_pkg::pmcd_word_t resp_word,
  // Mode status
  output logic prog_mode
);
  import pmcd_pkg::*;

  localparam logic [23:0] WIN_LAST = 24'(BIT_WINDOW_CYC - 1);

  // A window shorter than two cycles could never see a pulse in time
  generate
    if (BIT_WINDOW_CYC < 2 || BIT_WINDOW_CYC > 24'hFFFFFF)
    begin : g_bad_window
      $error("BIT_WINDOW_CYC out of range");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Helper functions

  // One LFSR division step
  function automatic logic [2:0] crc_step(input logic [2:0] c, input logic b);
    crc_step = {c[1:0], b} ^ (c[2] ? `PMCD_CRC_POLY : 3'h0);
  endfunction

  // Remainder over the first n payload bits, then the zero augmentation
  function automatic logic [2:0] crc_calc(input logic [21:0] p, input logic [4:0] n);
    logic [2:0] c;
    c = `PMCD_CRC_SEED;
    for (int i = 0; i < 22; i++)
    begin
      if (i < int'(n))
      begin
        c = crc_step(c, p[i]);
      end
    end
    for (int j = 0; j < `PMCD_CRC_PAD_BITS; j++)
    begin
      c = crc_step(c, 1'b0);
    end
    crc_calc = c;
  endfunction

  // Payload length before the CRC follows from the function code
  function automatic logic [4:0] payload_len(input logic [2:0] fc);
    payload_len = fc[2] ? `PMCD_PAYLOAD_SHORT :
                  (fc[1] ? `PMCD_PAYLOAD_LONG : `PMCD_PAYLOAD_XLONG);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // State

  pmcd_state_t state_r, state_nxt;
  logic [2:0] hist_r, hist_nxt;
  logic [1:0] phase_r, phase_nxt;
  logic [4:0] pay_cnt_r, pay_cnt_nxt;
  logic [21:0] payload_r, payload_nxt;
  logic [2:0] rx_crc_r, rx_crc_nxt;
  logic [2:0] zero_run_r, zero_run_nxt;
  logic [23:0] win_cnt_r, win_cnt_nxt;
  logic prog_mode_r, prog_mode_nxt;
  pmcd_word_t words_r [3];
  pmcd_word_t words_nxt [3];
  logic [1:0] resp_len_r, resp_len_nxt;
  logic [1:0] resp_idx_r, resp_idx_nxt;
  logic resp_valid_r, resp_valid_nxt;
  pmcd_word_t resp_word_r, resp_word_nxt;
  logic [7:0] reg_index_r, reg_index_nxt;
  logic reg_wr_r, reg_wr_nxt;
  logic [7:0] reg_wdata_r, reg_wdata_nxt;

  logic [2:0] function_code;
  logic [2:0] sensor_select;
  logic sa_ok;
  logic crc_ok;
  logic is_sync;
  logic timeout;

  // Command fields as they sit in the payload, LSB received first
  assign sensor_select = payload_r[2:0];
  assign function_code = payload_r[5:3];
  assign sa_ok = sensor_select == SENSOR_SELECT;
  assign crc_ok = crc_calc(payload_r, payload_len(function_code)) == rx_crc_r;
  assign is_sync = phase_r == `PMCD_SYNC_PHASE;
  // Only waits inside a command are timed; response syncs may arrive late
  assign timeout = (state_r == pmcd_st_rx) && !sync_pulse && (win_cnt_r == WIN_LAST);

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  always_comb
  begin
    state_nxt = state_r;
    hist_nxt = hist_r;
    phase_nxt = phase_r;
    pay_cnt_nxt = pay_cnt_r;
    payload_nxt = payload_r;
    rx_crc_nxt = rx_crc_r;
    zero_run_nxt = zero_run_r;
    prog_mode_nxt = prog_mode_r;
    words_nxt = words_r;
    resp_len_nxt = resp_len_r;
    resp_idx_nxt = resp_idx_r;
    resp_valid_nxt = 1'b0;
    resp_word_nxt = resp_word_r;
    reg_index_nxt = reg_index_r;
    reg_wr_nxt = 1'b0;
    reg_wdata_nxt = reg_wdata_r;
    win_cnt_nxt = (state_r != pmcd_st_rx || sync_pulse) ? 24'h0 : win_cnt_r + 24'h1;
    case (state_r)
      pmcd_st_idle:
      begin
        if (sync_pulse)
        begin
          hist_nxt = {hist_r[1:0], sync_bit};
          if ({hist_r[1:0], sync_bit} == `PMCD_START_PATTERN)
          begin
            state_nxt = pmcd_st_rx;
            hist_nxt = 3'h0;
            phase_nxt = `PMCD_SYNC_PHASE;
            pay_cnt_nxt = 5'h00;
            payload_nxt = 22'h0;
            zero_run_nxt = 3'h0;
          end
        end
      end
      pmcd_st_rx:
      begin
        if (timeout || (sync_pulse && !sync_bit &&
            zero_run_r + 3'h1 == `PMCD_ZERO_RUN_LIMIT))
        begin
          // Abort the frame; the next syncs carry a short framing error reply
          state_nxt = pmcd_st_resp;
          words_nxt[0] = `PMCD_RC_ERR;
          words_nxt[1] = {`PMCD_ERROR_NUMBER_PAD, `PMCD_ERROR_NUMBER_FRAMING};
          words_nxt[2] = `PMCD_WORD_ZERO;
          resp_len_nxt = `PMCD_RESP_SHORT;
          resp_idx_nxt = 2'h0;
        end
        else if (sync_pulse)
        begin
          zero_run_nxt = sync_bit ? 3'h0 : zero_run_r + 3'h1;
          phase_nxt = phase_r + 2'h1;
          if (!is_sync)
          begin
            if (pay_cnt_r < `PMCD_PAYLOAD_XLONG)
            begin
              payload_nxt[pay_cnt_r] = sync_bit;
            end
            rx_crc_nxt = {rx_crc_r[1:0], sync_bit}; // CRC arrives MSB first
            pay_cnt_nxt = pay_cnt_r + 5'h01;
            if (pay_cnt_r == payload_len(function_code) + `PMCD_CRC_LAST)
            begin
              state_nxt = pmcd_st_exec;
            end
          end
        end
      end
      pmcd_st_exec:
      begin
        state_nxt = pmcd_st_idle;
        words_nxt[0] = `PMCD_RC_OK;
        resp_idx_nxt = 2'h0;
        if (sa_ok)
        begin
          if (function_code[2])
          begin
            // Short: only entry is served, a failed one stays quiet
            if (crc_ok && function_code == `PMCD_FC_ENTER)
            begin
              prog_mode_nxt = 1'b1;
              words_nxt[1] = `PMCD_ENTER_ACK;
              resp_len_nxt = `PMCD_RESP_SHORT;
              state_nxt = pmcd_st_resp;
            end
          end
          else if (!function_code[1] && prog_mode_r)
          begin
            if (!crc_ok)
            begin
              words_nxt[0] = `PMCD_RC_ERR;
              words_nxt[1] = {`PMCD_ERROR_NUMBER_PAD, `PMCD_ERROR_NUMBER_CRC};
              words_nxt[2] = `PMCD_WORD_ZERO;
              resp_len_nxt = `PMCD_RESP_XLONG;
              state_nxt = pmcd_st_resp;
            end
            else if (function_code == `PMCD_FC_READ)
            begin
              reg_index_nxt = {payload_r[13:7], 1'b0};
              state_nxt = pmcd_st_rd_even;
            end
            else
            begin
              reg_index_nxt = payload_r[13:6];
              reg_wdata_nxt = payload_r[21:14];
              reg_wr_nxt = 1'b1;
              state_nxt = pmcd_st_wr_wait;
            end
          end
        end
      end
      pmcd_st_rd_even:
      begin
        words_nxt[1] = {`PMCD_BYTE_PAD, reg_rdata};
        reg_index_nxt = {reg_index_r[7:1], 1'b1};
        state_nxt = pmcd_st_rd_odd;
      end
      pmcd_st_rd_odd:
      begin
        words_nxt[2] = {`PMCD_BYTE_PAD, reg_rdata};
        resp_len_nxt = `PMCD_RESP_XLONG;
        state_nxt = pmcd_st_resp;
      end
      pmcd_st_wr_wait:
      begin
        // The write lands on this edge; contents are read a cycle later
        state_nxt = pmcd_st_wr_back;
      end
      pmcd_st_wr_back:
      begin
        words_nxt[1] = {`PMCD_BYTE_PAD, reg_rdata};
        words_nxt[2] = {`PMCD_BYTE_PAD, reg_index_r};
        resp_len_nxt = `PMCD_RESP_XLONG;
        state_nxt = pmcd_st_resp;
      end
      pmcd_st_resp:
      begin
        if (sync_pulse)
        begin
          resp_valid_nxt = 1'b1;
          resp_word_nxt = words_r[resp_idx_r];
          resp_idx_nxt = resp_idx_r + 2'h1;
          if (resp_idx_r + 2'h1 == resp_len_r)
          begin
            state_nxt = pmcd_st_idle;
          end
        end
      end
      default:
      begin
        state_nxt = pmcd_st_idle;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge core_clk)
  begin
    if (reset)
    begin
      state_r <= pmcd_st_idle;
      hist_r <= 3'h0;
      phase_r <= 2'h0;
      pay_cnt_r <= 5'h00;
      payload_r <= 22'h0;
      rx_crc_r <= 3'h0;
      zero_run_r <= 3'h0;
      win_cnt_r <= 24'h0;
      prog_mode_r <= 1'b0;
      words_r <= '{default: `PMCD_WORD_ZERO};
      resp_len_r <= 2'h0;
      resp_idx_r <= 2'h0;
      resp_valid_r <= 1'b0;
      resp_word_r <= `PMCD_WORD_ZERO;
      reg_index_r <= 8'h00;
      reg_wr_r <= 1'b0;
      reg_wdata_r <= 8'h00;
    end
    else
    begin
      state_r <= state_nxt;
      hist_r <= hist_nxt;
      phase_r <= phase_nxt;
      pay_cnt_r <= pay_cnt_nxt;
      payload_r <= payload_nxt;
      rx_crc_r <= rx_crc_nxt;
      zero_run_r <= zero_run_nxt;
      win_cnt_r <= win_cnt_nxt;
      prog_mode_r <= prog_mode_nxt;
      words_r <= words_nxt;
      resp_len_r <= resp_len_nxt;
      resp_idx_r <= resp_idx_nxt;
      resp_valid_r <= resp_valid_nxt;
      resp_word_r <= resp_word_nxt;
      reg_index_r <= reg_index_nxt;
      reg_wr_r <= reg_wr_nxt;
      reg_wdata_r <= reg_wdata_nxt;
    end
  end

  // Outputs straight from flip-flops
  assign register_index = reg_index_r;
  assign reg_wr_en = reg_wr_r;
  assign reg_wdata = reg_wdata_r;
  assign resp_valid = resp_valid_r;
  assign resp_word = resp_word_r;
  assign prog_mode = prog_mode_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_enter_ack: assert property (@(posedge core_clk) disable iff (reset)
    (state_r == pmcd_st_exec && sa_ok && crc_ok && function_code == `PMCD_FC_ENTER)
    |=> prog_mode_r && words_r[1] == `PMCD_ENTER_ACK && resp_len_r == `PMCD_RESP_SHORT)
    else $error("entry command not acknowledged");
  a_invalid_silent: assert property (@(posedge core_clk) disable iff (reset)
    (state_r == pmcd_st_exec && function_code[2:1] != 2'h0 &&
     function_code != `PMCD_FC_ENTER) |=> state_r == pmcd_st_idle)
    else $error("invalid command answered");
  a_read_pair: assert property (@(posedge core_clk) disable iff (reset)
    (state_r == pmcd_st_rd_even) |-> !reg_index_r[0]
    ##1 (reg_index_r[0] && words_r[1] == {`PMCD_BYTE_PAD, $past(reg_rdata)}))
    else $error("read pair out of order");
  a_write_reply: assert property (@(posedge core_clk) disable iff (reset)
    (state_r == pmcd_st_wr_back) |=> state_r == pmcd_st_resp &&
    words_r[2] == {`PMCD_BYTE_PAD, $past(reg_index_r)} && words_r[0] == `PMCD_RC_OK)
    else $error("write reply wrong");
  a_code_value: assert property (@(posedge core_clk) disable iff (reset)
    (state_r == pmcd_st_resp) |-> (words_r[0] == `PMCD_RC_OK || words_r[0] == `PMCD_RC_ERR))
    else $error("bad response code");
  a_error_layout: assert property (@(posedge core_clk) disable iff (reset)
    (state_r == pmcd_st_resp && words_r[0] == `PMCD_RC_ERR) |->
    (words_r[1] == {`PMCD_ERROR_NUMBER_PAD, `PMCD_ERROR_NUMBER_FRAMING} ||
     words_r[1] == {`PMCD_ERROR_NUMBER_PAD, `PMCD_ERROR_NUMBER_CRC}) && words_r[2] == `PMCD_WORD_ZERO)
    else $error("error reply layout wrong");
  a_zero_run: assert property (@(posedge core_clk) disable iff (reset)
    (state_r == pmcd_st_rx && sync_pulse && !sync_bit && zero_run_r == 3'h3) |=>
    state_r == pmcd_st_resp && words_r[1] == {`PMCD_ERROR_NUMBER_PAD, `PMCD_ERROR_NUMBER_FRAMING})
    else $error("zero run not flagged");
  a_crc_error: assert property (@(posedge core_clk) disable iff (reset)
    (state_r == pmcd_st_exec && sa_ok && !crc_ok && prog_mode_r && function_code[2:1] == 2'h0)
    |=> words_r[1] == {`PMCD_ERROR_NUMBER_PAD, `PMCD_ERROR_NUMBER_CRC} && resp_len_r == `PMCD_RESP_XLONG)
    else $error("crc error not reported");
  a_foreign_addr: assert property (@(posedge core_clk) disable iff (reset)
    (state_r == pmcd_st_exec && !sa_ok) |=> state_r == pmcd_st_idle && $stable(prog_mode_r))
    else $error("foreign address answered");
  a_timeout_abort: assert property (@(posedge core_clk) disable iff (reset)
    timeout |=> state_r == pmcd_st_resp && words_r[0] == `PMCD_RC_ERR
    && resp_len_r == `PMCD_RESP_SHORT)
    else $error("timeout not aborted");
  a_slot_order: assert property (@(posedge core_clk) disable iff (reset)
    (state_r == pmcd_st_resp && sync_pulse && resp_idx_r == 2'h0) |=>
    resp_valid_r && resp_word_r == $past(words_r[0]))
    else $error("first slot is not the code");
endmodule

/* File: testbench/pmcd_host_model.sv */
`timescale 1ns/10ps
// Bus master model: sends command frames and response sync pulses
module pmcd_host_model (
  // Clock
  input wire logic core_clk,
  // Decoded sync pulses toward the decoder
  output logic sync_pulse,
  output logic sync_bit
);
  initial
  begin
    sync_pulse = 1'b0;
    sync_bit = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // One bit per pulse; the bit line is inverted between pulses so stale data never helps
  task automatic put_bit(input logic b);
    @(negedge core_clk);
    sync_pulse = 1'b1;
    sync_bit = b;
    @(negedge core_clk);
    sync_pulse = 1'b0;
    sync_bit = ~b;
    repeat (2) @(negedge core_clk);
  endtask

  // Start pattern, then payload and check bits with a sync bit ahead of every third
  task automatic send_cmd(input logic [21:0] pl, input int n, input logic bad);
    logic [2:0] crc;
    logic msb;
    crc = 3'h7;
    for (int i = 0; i < n + 3; i++)
    begin
      msb = crc[2];
      crc = {crc[1:0], (i < n) ? pl[i] : 1'b0};
      if (msb)
        crc = crc ^ 3'h3;
    end
    put_bit(1'b0);
    put_bit(1'b1);
    put_bit(1'b0);
    for (int k = 0; k < n + 3; k++)
    begin
      if (k % 3 == 0)
        put_bit(1'b1);
      // Check bits go out MSB first; a bad frame has its last check bit flipped
      put_bit((k < n) ? pl[k] : (crc[2 - (k - n)] ^ (bad && k == n + 2)));
    end
  endtask

  // Response syncs sent back to back, one per expected word
  task automatic resp_syncs(input int n);
    repeat (8) @(negedge core_clk);
    for (int i = 0; i < n; i++)
    begin
      @(negedge core_clk);
      sync_pulse = 1'b1;
      @(negedge core_clk);
      sync_pulse = 1'b0;
    end
    repeat (4) @(negedge core_clk);
  endtask
endmodule

/* File: testbench/pmcd_decoder_bench.sv */
`timescale 1ns/10ps
`define CHK(what, exp, got) \
  begin \
    comparisons++; \
    if ((got) !== (exp)) \
    begin \
      n_fail++; \
      $display("mismatch %s expected %h seen %h", what, exp, got); \
    end \
  end
module pmcd_decoder_bench;
  import pmcd_pkg::*;
  typedef struct {
    logic [2:0] sa;
    logic [2:0] fc;
    logic [7:0] ra;
    logic [7:0] d;
    logic bad;
    int n;
    pmcd_word_t w [3];
  } pmcd_row_t;
  logic core_clk = 1'b0;
  logic reset = 1'b1;
  logic sync_pulse;
  logic sync_bit;
  logic [7:0] register_index;
  logic reg_wr_en;
  logic [7:0] reg_wdata;
  logic [7:0] reg_rdata;
  logic resp_valid;
  pmcd_word_t resp_word;
  logic prog_mode;
  logic [7:0] regs [256];
  pmcd_word_t got [$];
  pmcd_row_t rows [17];
  int n_fail = 0;
  int comparisons = 0;
  // Host wait after the unlock write; the value is arbitrary, the memory sets the real one
  localparam int otp_program_delay_cyc = 50;

  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////////////////////////
  // Short bit window keeps the timeout case brief
  pmcd_decoder #(.BIT_WINDOW_CYC(20)) DUT (.core_clk(core_clk), .reset(reset),
    .sync_pulse(sync_pulse), .sync_bit(sync_bit), .register_index(register_index),
    .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .resp_valid(resp_valid), .resp_word(resp_word), .prog_mode(prog_mode));
  pmcd_host_model host (.core_clk(core_clk), .sync_pulse(sync_pulse), .sync_bit(sync_bit));

  // Register file: combinational read, write on the pulse
  assign reg_rdata = regs[register_index];
  always @(posedge core_clk)
  begin
    if (reg_wr_en === 1'b1)
      regs[register_index] <= reg_wdata;
  end

  // Response words are collected at the falling edge, where they have settled
  always @(negedge core_clk)
  begin
    if (resp_valid === 1'b1)
      got.push_back(resp_word);
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop();
    if (n_fail == 0 && comparisons > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // Compare the collected reply with the expected count and words
  task automatic expect_resp(input int n, input pmcd_word_t e [3]);
    `CHK("word count", n, got.size())
    for (int i = 0; i < n && i < got.size(); i++)
      `CHK("response word", e[i], got[i])
    got.delete();
  endtask

  // Hang guard: a run this long counts as a failure
  initial
  begin
    repeat (100000) @(posedge core_clk);
    n_fail++;
    $display("mismatch watchdog expected end seen hang");
    report_and_stop();
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 256; i++)
      regs[i] = 8'(i) ^ 8'hA5;
    // Extra-long before entry, bad short, foreign address, invalid codes
    rows[0] = '{3'h1, 3'h0, 8'h35, 8'h00, 1'b0, 0, '{10'h000, 10'h000, 10'h000}};
    rows[1] = '{3'h1, 3'h7, 8'h00, 8'h00, 1'b1, 0, '{10'h000, 10'h000, 10'h000}};
    rows[2] = '{3'h2, 3'h7, 8'h00, 8'h00, 1'b0, 0, '{10'h000, 10'h000, 10'h000}};
    rows[3] = '{3'h1, 3'h4, 8'h00, 8'h00, 1'b0, 0, '{10'h000, 10'h000, 10'h000}};
    rows[4] = '{3'h1, 3'h5, 8'h00, 8'h00, 1'b0, 0, '{10'h000, 10'h000, 10'h000}};
    rows[5] = '{3'h1, 3'h6, 8'h00, 8'h00, 1'b0, 0, '{10'h000, 10'h000, 10'h000}};
    rows[6] = '{3'h1, 3'h2, 8'h12, 8'h34, 1'b0, 0, '{10'h000, 10'h000, 10'h000}};
    rows[7] = '{3'h1, 3'h3, 8'h12, 8'h34, 1'b0, 0, '{10'h000, 10'h000, 10'h000}};
    // Entry, then the load-and-verify flow of the host
    rows[8] = '{3'h1, 3'h7, 8'h00, 8'h00, 1'b0, 2, '{10'h1E1, 10'h0CA, 10'h000}};
    rows[9] = '{3'h1, 3'h0, 8'h35, 8'h00, 1'b0, 3, '{10'h1E1, 10'h091, 10'h090}};
    rows[10] = '{3'h1, 3'h1, 8'h47, 8'h3C, 1'b0, 3, '{10'h1E1, 10'h03C, 10'h047}};
    rows[11] = '{3'h1, 3'h0, 8'h46, 8'h00, 1'b0, 3, '{10'h1E1, 10'h0E3, 10'h03C}};
    rows[12] = '{3'h1, 3'h0, 8'h46, 8'h00, 1'b1, 3, '{10'h1E2, 10'h002, 10'h000}};
    rows[13] = '{3'h3, 3'h1, 8'h47, 8'h55, 1'b0, 0, '{10'h000, 10'h000, 10'h000}};
    // Unlock write, status read after the wait, invalid long code once in the mode
    // Unlock register index and byte are arbitrary stand-ins
    rows[14] = '{3'h1, 3'h1, 8'h14, 8'h5A, 1'b0, 3, '{10'h1E1, 10'h05A, 10'h014}};
    rows[15] = '{3'h1, 3'h0, 8'h12, 8'h00, 1'b0, 3, '{10'h1E1, 10'h0B7, 10'h0B6}};
    rows[16] = '{3'h1, 3'h3, 8'h12, 8'h34, 1'b0, 0, '{10'h000, 10'h000, 10'h000}};
    repeat (4) @(negedge core_clk);
    `CHK("prog_mode in reset", 1'b0, prog_mode)
    `CHK("resp_valid in reset", 1'b0, resp_valid)
    reset = 1'b0;
    // Table pass; silent rows still get syncs so a stray reply would show
    for (int r = 0; r < 17; r++)
    begin
      if (r == 15)
        repeat (otp_program_delay_cyc) @(negedge core_clk);
      host.send_cmd({rows[r].d, rows[r].ra, rows[r].fc, rows[r].sa},
        rows[r].fc[2] ? 6 : (rows[r].fc[1] ? 16 : 22), rows[r].bad);
      host.resp_syncs(rows[r].n == 0 ? 3 : rows[r].n);
      expect_resp(rows[r].n, rows[r].w);
    end
    `CHK("prog_mode", 1'b1, prog_mode)
    // Four zeros in a row: sync bit after the address is sent low
    for (int k = 0; k < 8; k++)
      host.put_bit(k == 1 || k == 3);
    host.resp_syncs(2);
    expect_resp(2, '{10'h1E2, 10'h001, 10'h000});
    // Frame stalls past the bit window, next syncs get the framing reply
    for (int k = 0; k < 5; k++)
      host.put_bit(k == 1 || k >= 3);
    repeat (40) @(negedge core_clk);
    host.resp_syncs(2);
    expect_resp(2, '{10'h1E2, 10'h001, 10'h000});
    // Reset in mid-run drops programming mode
    reset = 1'b1;
    @(negedge core_clk);
    @(negedge core_clk);
    `CHK("prog_mode after reset", 1'b0, prog_mode)
    reset = 1'b0;
    repeat (2) @(negedge core_clk);
    `CHK("resp_valid after release", 1'b0, resp_valid)
    // Register access without a fresh entry must stay silent
    host.send_cmd({8'h00, 8'h35, 3'h0, 3'h1}, 22, 1'b0);
    host.resp_syncs(3);
    expect_resp(0, '{10'h000, 10'h000, 10'h000});
    report_and_stop();
  end
endmodule
